// >>> core/bmpc_map.svh
// Offsets, field positions, reset values and timing counts of the burst/protection sequencer
`ifndef BMPC_MAP_SVH
`define BMPC_MAP_SVH

`define BMPC_CLK_HZ 40000000
`define BMPC_CLK_MHZ 40

// Burst-mode timer, nominal 50 kHz, duty limited to 50 %
`define BMPC_BURST_HZ 50000
`define BMPC_BURST_PERIOD_CYC (`BMPC_CLK_HZ / `BMPC_BURST_HZ)
`define BMPC_BURST_HALF_CYC (`BMPC_BURST_PERIOD_CYC / 2)

// Longest on-time, rounded down
`define BMPC_ONMAX_NS 30000
`define BMPC_ONMAX_CYC ((`BMPC_ONMAX_NS * `BMPC_CLK_MHZ) / 1000)

// Least blanking times, rounded up
`define BMPC_SW_BLANK_NS 200
`define BMPC_SW_BLANK_CYC ((`BMPC_SW_BLANK_NS * `BMPC_CLK_MHZ + 999) / 1000)
`define BMPC_OVP_BLANK_NS 1000
`define BMPC_OVP_BLANK_CYC ((`BMPC_OVP_BLANK_NS * `BMPC_CLK_MHZ + 999) / 1000)
`define BMPC_BEB_NS 20000
`define BMPC_BEB_CYC ((`BMPC_BEB_NS * `BMPC_CLK_MHZ + 999) / 1000)
`define BMPC_OVL_BLANK_MS 24
`define BMPC_OVL_BLANK_CYC (`BMPC_OVL_BLANK_MS * `BMPC_CLK_MHZ * 1000)

// Valley counter values
`define BMPC_UD_ENTRY_VAL 3'h7

// Comparator flag positions
`define BMPC_FLAG_W 14
`define BMPC_FL_FB_ENTRY 0
`define BMPC_FL_FB_BH 1
`define BMPC_FL_FB_BL 2
`define BMPC_FL_FB_EXIT 3
`define BMPC_FL_FB_OVL 4
`define BMPC_FL_CS_PEAK 5
`define BMPC_FL_CS_BURST 6
`define BMPC_FL_CS_SW 7
`define BMPC_FL_ZC_OVP 8
`define BMPC_FL_OTP 9
`define BMPC_FL_VCC_UV 10
`define BMPC_FL_VCC_OV 11
`define BMPC_FL_VCC_OFF 12
`define BMPC_FL_VCC_ON 13

// Register byte offsets
`define BMPC_REG_CTRL 8'h00
`define BMPC_REG_STATUS 8'h04
`define BMPC_REG_INT_STAT 8'h08
`define BMPC_REG_INT_MASK 8'h0C
`define BMPC_CTRL_RST 1'b1
`define BMPC_MASK_RST 5'h00

// Event bit positions in status and mask
`define BMPC_EV_W 5
`define BMPC_EV_BURST_IN 0
`define BMPC_EV_BURST_OUT 1
`define BMPC_EV_RESTART 2
`define BMPC_EV_LATCH 3
`define BMPC_EV_MAXON 4

`endif

// >>> core/bmpc_pkg.sv
// Types of the burst/protection sequencer
`default_nettype none
package bmpc_pkg;
  typedef enum logic [2:0] {
    ST_CHARGE = 3'b000,
    ST_RUN = 3'b001,
    ST_BURST_PAUSE = 3'b010,
    ST_BURST_ACTIVE = 3'b011,
    ST_RESTART = 3'b100,
    ST_LATCH = 3'b101
  } bmpc_state_t;
endpackage
`default_nettype wire

// >>> core/bmpc_flag_if.sv
// Raw and cleaned comparator flags between the sequencer and its synchroniser
`default_nettype none
`include "bmpc_map.svh"
interface bmpc_flag_if;
  logic [`BMPC_FLAG_W-1:0] raw;
  logic [`BMPC_FLAG_W-1:0] clean;
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface
`default_nettype wire

// >>> core/bmpc_sync.sv
// Three-stage synchroniser with agreement filter for comparator flags
`default_nettype none
`include "bmpc_map.svh"
module bmpc_sync (
  input wire logic mclk,
  input wire logic reset,
  bmpc_flag_if.sync flags
);
  logic [`BMPC_FLAG_W-1:0] s1_ff;
  logic [`BMPC_FLAG_W-1:0] s2_ff;
  logic [`BMPC_FLAG_W-1:0] s3_ff;
  logic [`BMPC_FLAG_W-1:0] clean_ff;

  // Only s2 reads s1; a change counts once s2 and s3 agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      clean_ff <= '0;
    end else begin
      s1_ff <= flags.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < `BMPC_FLAG_W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          clean_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign flags.clean = clean_ff;
endmodule // bmpc_sync
`default_nettype wire

// >>> core/bmpc_core.sv
// Burst-mode and protection sequencer with APB registers
//
// Implementation choices: the register addresses and the APB interface to the registers.
`default_nettype none
`include "bmpc_map.svh"
module bmpc_core #(
  parameter int unsigned OVL_BLANK_CYC = `BMPC_OVL_BLANK_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`BMPC_FLAG_W-1:0] compFlags,
  input wire logic [2:0] udCount,
  input wire logic valleyOnReq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic gateDrive,
  output logic biasEnable,
  output logic startupCellEn,
  output logic burstLimitSel,
  output logic udLoadOne,
  output logic softStart,
  output logic irq
);
  localparam int BURST_HALF = `BMPC_BURST_HALF_CYC;
  localparam int ONMAX = `BMPC_ONMAX_CYC;

  bmpc_flag_if flagBus ();
  assign flagBus.raw = compFlags;

  bmpc_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .flags(flagBus)
  );

  logic [`BMPC_FLAG_W-1:0] fl;
  assign fl = flagBus.clean;

  bmpc_pkg::bmpc_state_t state_ff;
  logic gate_ff;
  logic bias_ff;
  logic startup_ff;
  logic udLoad_ff;
  logic soft_ff;
  logic [9:0] burstTmr_ff;
  logic [10:0] onCnt_ff;
  logic [10:0] beCnt_ff;
  logic [19:0] ovlCnt_ff;
  logic [5:0] ovpCnt_ff;
  logic [3:0] swCnt_ff;
  logic ctrlEn_ff;
  logic [`BMPC_EV_W-1:0] intStat_ff;
  logic [`BMPC_EV_W-1:0] intMask_ff;
  logic irq_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  logic running;
  logic inBurst;
  logic beHit;
  logic ovlHit;
  logic ovpHit;
  logic swHit;
  logic faultLatch;
  logic faultAuto;
  logic maxOnHit;
  logic burstOffHit;
  logic [`BMPC_EV_W-1:0] events;

  assign running = (state_ff == bmpc_pkg::ST_RUN) || inBurst;
  assign inBurst = (state_ff == bmpc_pkg::ST_BURST_PAUSE) ||
                   (state_ff == bmpc_pkg::ST_BURST_ACTIVE);
  assign beHit = beCnt_ff == 11'(`BMPC_BEB_CYC);
  assign ovlHit = ovlCnt_ff == 20'(OVL_BLANK_CYC);
  assign ovpHit = ovpCnt_ff == 6'(`BMPC_OVP_BLANK_CYC);
  assign swHit = swCnt_ff == 4'(`BMPC_SW_BLANK_CYC);
  assign maxOnHit = gate_ff && (onCnt_ff == 11'(ONMAX - 1));
  assign burstOffHit = fl[`BMPC_FL_CS_BURST] || (burstTmr_ff >= 10'(BURST_HALF));
  // Latching faults take priority over auto-restart ones
  assign faultLatch = running && (ovpHit || swHit);
  assign faultAuto = running && (fl[`BMPC_FL_VCC_UV] || fl[`BMPC_FL_VCC_OV] ||
                     fl[`BMPC_FL_OTP] || ovlHit);

  // Blanking counters saturate while their condition holds, clear otherwise
  always_ff @(posedge mclk) begin
    if (reset || state_ff != bmpc_pkg::ST_RUN || !fl[`BMPC_FL_FB_ENTRY] ||
        udCount != `BMPC_UD_ENTRY_VAL) begin
      beCnt_ff <= '0;
    end else if (!beHit) begin
      beCnt_ff <= beCnt_ff + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !running || !fl[`BMPC_FL_FB_OVL]) begin
      ovlCnt_ff <= '0;
    end else if (!ovlHit) begin
      ovlCnt_ff <= ovlCnt_ff + 20'h0_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !running || gate_ff || !fl[`BMPC_FL_ZC_OVP]) begin
      ovpCnt_ff <= '0;
    end else if (!ovpHit) begin
      ovpCnt_ff <= ovpCnt_ff + 6'h01;
    end
  end

  // Spike filter: a pulse shorter than the blanking never reaches the latch
  always_ff @(posedge mclk) begin
    if (reset || !running || !gate_ff || !fl[`BMPC_FL_CS_SW]) begin
      swCnt_ff <= '0;
    end else if (!swHit) begin
      swCnt_ff <= swCnt_ff + 4'h1;
    end
  end

  // Free-running so burst pulses keep their nominal rate across pauses
  always_ff @(posedge mclk) begin
    if (reset || burstTmr_ff == 10'(`BMPC_BURST_PERIOD_CYC - 1)) begin
      burstTmr_ff <= '0;
    end else begin
      burstTmr_ff <= burstTmr_ff + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !gate_ff) begin
      onCnt_ff <= '0;
    end else begin
      onCnt_ff <= onCnt_ff + 11'h001;
    end
  end

  // Mode sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= bmpc_pkg::ST_CHARGE;
      bias_ff <= 1'b0;
      startup_ff <= 1'b1;
      udLoad_ff <= 1'b0;
      soft_ff <= 1'b0;
    end else begin
      udLoad_ff <= 1'b0;
      soft_ff <= 1'b0;
      if (faultLatch) begin
        state_ff <= bmpc_pkg::ST_LATCH;
        bias_ff <= 1'b0;
      end else if (faultAuto) begin
        state_ff <= bmpc_pkg::ST_RESTART;
        bias_ff <= 1'b0;
      end else begin
        case (state_ff)
          bmpc_pkg::ST_CHARGE: begin
            startup_ff <= 1'b1;
            if (fl[`BMPC_FL_VCC_ON]) begin
              state_ff <= bmpc_pkg::ST_RUN;
              startup_ff <= 1'b0;
              bias_ff <= 1'b1;
              soft_ff <= 1'b1;
            end
          end
          bmpc_pkg::ST_RUN: begin
            if (beHit) begin
              state_ff <= bmpc_pkg::ST_BURST_PAUSE;
              bias_ff <= 1'b0;
            end
          end
          bmpc_pkg::ST_BURST_PAUSE, bmpc_pkg::ST_BURST_ACTIVE: begin
            if (fl[`BMPC_FL_FB_EXIT]) begin
              state_ff <= bmpc_pkg::ST_RUN;
              bias_ff <= 1'b1;
              udLoad_ff <= 1'b1;
            end else if (state_ff == bmpc_pkg::ST_BURST_PAUSE && fl[`BMPC_FL_FB_BH]) begin
              state_ff <= bmpc_pkg::ST_BURST_ACTIVE;
              bias_ff <= 1'b1;
            end else if (state_ff == bmpc_pkg::ST_BURST_ACTIVE && fl[`BMPC_FL_FB_BL]) begin
              state_ff <= bmpc_pkg::ST_BURST_PAUSE;
              bias_ff <= 1'b0;
            end
          end
          bmpc_pkg::ST_RESTART: begin
            startup_ff <= 1'b0;
            if (fl[`BMPC_FL_VCC_OFF]) begin
              state_ff <= bmpc_pkg::ST_CHARGE;
              startup_ff <= 1'b1;
            end
          end
          bmpc_pkg::ST_LATCH: begin
            // Only reset leaves this state
            if (fl[`BMPC_FL_VCC_OFF]) begin
              startup_ff <= 1'b1;
            end else if (fl[`BMPC_FL_VCC_ON]) begin
              startup_ff <= 1'b0;
            end
          end
          default: begin
            state_ff <= bmpc_pkg::ST_CHARGE;
            bias_ff <= 1'b0;
            startup_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // Gate flip-flop: any turn-off cause clears it, turn-on only when none is pending
  always_ff @(posedge mclk) begin
    if (reset || faultLatch || faultAuto || !ctrlEn_ff) begin
      gate_ff <= 1'b0;
    end else if (maxOnHit) begin
      gate_ff <= 1'b0;
    end else if (state_ff == bmpc_pkg::ST_RUN) begin
      if (gate_ff && fl[`BMPC_FL_CS_PEAK]) begin
        gate_ff <= 1'b0;
      end else if (!gate_ff && valleyOnReq) begin
        gate_ff <= 1'b1;
      end
    end else if (state_ff == bmpc_pkg::ST_BURST_ACTIVE) begin
      if (gate_ff && burstOffHit) begin
        gate_ff <= 1'b0;
      end else if (!gate_ff && burstTmr_ff == 10'h000 && !fl[`BMPC_FL_FB_BL]) begin
        gate_ff <= 1'b1;
      end
    end else begin
      gate_ff <= 1'b0;
    end
  end

  assign events[`BMPC_EV_BURST_IN] = !faultLatch && !faultAuto &&
                                     state_ff == bmpc_pkg::ST_RUN && beHit;
  assign events[`BMPC_EV_BURST_OUT] = !faultLatch && !faultAuto && inBurst &&
                                      fl[`BMPC_FL_FB_EXIT];
  assign events[`BMPC_EV_RESTART] = faultAuto && !faultLatch;
  assign events[`BMPC_EV_LATCH] = faultLatch;
  assign events[`BMPC_EV_MAXON] = maxOnHit;

  // APB slave: pready follows one cycle into the access phase
  logic apbAcc;
  logic apbDone;
  logic addrOk;
  assign apbAcc = psel && penable && !pready_ff;
  assign apbDone = psel && penable && pready_ff;
  assign addrOk = (paddr == `BMPC_REG_CTRL) || (paddr == `BMPC_REG_STATUS) ||
                  (paddr == `BMPC_REG_INT_STAT) || (paddr == `BMPC_REG_INT_MASK);

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= apbAcc;
      pslverr_ff <= apbAcc && !addrOk;
      prdata_ff <= 32'h0000_0000;
      if (apbAcc && !pwrite) begin
        case (paddr)
          `BMPC_REG_CTRL: prdata_ff <= {31'h0000_0000, ctrlEn_ff};
          `BMPC_REG_STATUS: prdata_ff <= {25'h000_0000, burstLimitSel, startup_ff,
                                          bias_ff, gate_ff, state_ff};
          `BMPC_REG_INT_STAT: prdata_ff <= {27'h000_0000, intStat_ff};
          `BMPC_REG_INT_MASK: prdata_ff <= {27'h000_0000, intMask_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrlEn_ff <= `BMPC_CTRL_RST;
      intMask_ff <= `BMPC_MASK_RST;
    end else if (apbDone && pwrite) begin
      if (paddr == `BMPC_REG_CTRL) begin
        ctrlEn_ff <= pwdata[0];
      end
      if (paddr == `BMPC_REG_INT_MASK) begin
        intMask_ff <= pwdata[`BMPC_EV_W-1:0];
      end
    end
  end

  // A new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      intStat_ff <= '0;
    end else if (apbDone && pwrite && paddr == `BMPC_REG_INT_STAT) begin
      intStat_ff <= (intStat_ff & ~pwdata[`BMPC_EV_W-1:0]) | events;
    end else begin
      intStat_ff <= intStat_ff | events;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(intStat_ff & intMask_ff);
    end
  end

  logic burstSel_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      burstSel_ff <= 1'b0;
    end else begin
      burstSel_ff <= inBurst;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign gateDrive = gate_ff;
  assign biasEnable = bias_ff;
  assign startupCellEn = startup_ff;
  assign burstLimitSel = burstSel_ff;
  assign udLoadOne = udLoad_ff;
  assign softStart = soft_ff;
  assign irq = irq_ff;

  AST_BURST_ENTRY: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == bmpc_pkg::ST_BURST_PAUSE && $past(state_ff) == bmpc_pkg::ST_RUN)
    |-> $past(beHit) && $past(udCount) == `BMPC_UD_ENTRY_VAL)
    else $error("burst entered without its conditions");

  AST_BURST_WAKE: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == bmpc_pkg::ST_BURST_PAUSE && fl[`BMPC_FL_FB_BH] &&
     !fl[`BMPC_FL_FB_EXIT] && !faultLatch && !faultAuto)
    |=> state_ff == bmpc_pkg::ST_BURST_ACTIVE && biasEnable)
    else $error("paused burst did not wake");

  AST_BURST_TIMER: assert property (@(posedge mclk) disable iff (reset)
    ($rose(gate_ff) && state_ff == bmpc_pkg::ST_BURST_ACTIVE) |-> burstTmr_ff == 10'h001)
    else $error("burst pulse not started by timer");

  AST_BURST_CS_OFF: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == bmpc_pkg::ST_BURST_ACTIVE && gate_ff && fl[`BMPC_FL_CS_BURST]) |=> !gate_ff)
    else $error("burst pulse passed current limit");

  AST_BURST_DUTY: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == bmpc_pkg::ST_BURST_ACTIVE && gate_ff) |-> burstTmr_ff <= BURST_HALF)
    else $error("burst pulse passed half period");

  AST_BURST_SLEEP: assert property (@(posedge mclk) disable iff (reset)
    (state_ff == bmpc_pkg::ST_BURST_ACTIVE && fl[`BMPC_FL_FB_BL] &&
     !fl[`BMPC_FL_FB_EXIT] && !faultLatch && !faultAuto)
    |=> state_ff == bmpc_pkg::ST_BURST_PAUSE ##1 !gate_ff && !biasEnable)
    else $error("burst did not pause at low level");

  AST_EXIT_LOAD: assert property (@(posedge mclk) disable iff (reset)
    (inBurst && fl[`BMPC_FL_FB_EXIT] && !faultLatch && !faultAuto)
    |=> udLoadOne && state_ff == bmpc_pkg::ST_RUN ##1 !udLoadOne && !burstLimitSel)
    else $error("burst exit did not load valley counter");

  AST_MAX_ON: assert property (@(posedge mclk) disable iff (reset)
    gate_ff |-> onCnt_ff < ONMAX)
    else $error("gate high past maximum on-time");

  AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (reset)
    $past(state_ff) == bmpc_pkg::ST_LATCH |-> state_ff == bmpc_pkg::ST_LATCH && !gate_ff)
    else $error("latched-off state left or gate driven");

  AST_OVL_SHORT: assert property (@(posedge mclk) disable iff (reset)
    (running && !fl[`BMPC_FL_FB_OVL]) |=> ovlCnt_ff == 20'h0_0000 &&
    state_ff != bmpc_pkg::ST_RESTART || $past(faultAuto))
    else $error("overload blanking not restarted");
endmodule // bmpc_core
`default_nettype wire

// >>> tb/bmpc_plant.sv
// Comparator and supply model of the power stage facing the sequencer
`default_nettype none
module bmpc_plant #(
  parameter int VCC_OV_MV = 25000
) (
  input wire logic mclk,
  input wire logic gateDrive,
  input var int fbMv,
  input var int vccMv,
  input var int slope,
  input wire logic otp,
  input wire logic zcOvp,
  input wire logic swShort,
  output logic [13:0] compFlags
);
  int onCnt = 0;
  int csMv;
  // Sense current ramps only while the switch conducts
  always @(posedge mclk) begin
    onCnt <= gateDrive ? onCnt + 1 : 0;
  end
  // Aux winding is clamped during on-time, so overvoltage shows only in off-time
  always_comb begin
    csMv = onCnt * slope;
    compFlags = '0;
    compFlags[0] = fbMv < 1250;
    compFlags[1] = fbMv > 3600;
    compFlags[2] = fbMv <= 3000;
    compFlags[3] = fbMv > 4500;
    compFlags[4] = fbMv >= 4900;
    compFlags[5] = csMv >= 1030;
    compFlags[6] = csMv >= 340;
    compFlags[7] = swShort && gateDrive;
    compFlags[8] = zcOvp && !gateDrive;
    compFlags[9] = otp;
    compFlags[10] = vccMv <= 10500;
    compFlags[11] = vccMv > VCC_OV_MV;
    compFlags[12] = vccMv <= 10500;
    compFlags[13] = vccMv >= 18000;
  end
endmodule // bmpc_plant
`default_nettype wire

// >>> tb/burst_mode_protection_ctrl_test.sv
// Self-checking bench for the burst and protection sequencer
`default_nettype none
`include "bmpc_map.svh"
module burst_mode_protection_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset, psel, penable, pwrite, valleyOnReq, otp, zcOvp, swShort, apbErr;
  logic pready, pslverr, gateDrive, biasEnable, startupCellEn, burstLimitSel;
  logic udLoadOne, softStart, irq;
  logic gateQ = 1'b0;
  logic [2:0] udCount;
  logic [7:0] paddr;
  logic [13:0] compFlags;
  logic [31:0] pwdata, prdata, rd;
  int fbMv, vccMv, slope, w, p, c, n0;
  int err_count = 0;
  int checks = 0;
  int udCnt = 0;
  int softCnt = 0;
  int rises = 0;
  always #12.5 mclk = ~mclk;
  // Pulses are counted as they happen, since they stand for one cycle only
  always @(posedge mclk) begin
    udCnt <= udCnt + int'(udLoadOne === 1'b1);
    softCnt <= softCnt + int'(softStart === 1'b1);
    gateQ <= gateDrive;
    rises <= rises + int'(gateDrive === 1'b1 && gateQ === 1'b0);
  end
  bmpc_core #(.OVL_BLANK_CYC(50)) dut_u (.mclk(mclk), .reset(reset), .compFlags(compFlags),
    .udCount(udCount), .valleyOnReq(valleyOnReq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gateDrive(gateDrive), .biasEnable(biasEnable),
    .startupCellEn(startupCellEn), .burstLimitSel(burstLimitSel), .udLoadOne(udLoadOne),
    .softStart(softStart), .irq(irq));
  bmpc_plant plant_u (.mclk(mclk), .gateDrive(gateDrive), .fbMv(fbMv), .vccMv(vccMv),
    .slope(slope), .otp(otp), .zcOvp(zcOvp), .swShort(swShort), .compFlags(compFlags));
  task automatic stop_test();
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpRange(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  // One transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    apbErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask
  // Polls a register until the masked value appears, with a bounded count
  task automatic waitReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, '0);
      n++;
    end while ((rd & m) !== v && n < 3000);
    cmp(rd & m, v);
    if ((rd & m) !== v) begin
      stop_test();
    end
  endtask
  // Width of the next whole gate pulse and the rise-to-rise period
  task automatic gateWidth();
    int n;
    n = 0;
    while (gateDrive !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    while (gateDrive !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    w = 0;
    while (gateDrive === 1'b1 && n < 5000) begin
      @(posedge mclk);
      w++;
      n++;
    end
    p = w;
    while (gateDrive !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      p++;
      n++;
    end
    if (n >= 5000) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic doReset();
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(57316));
    reset <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    udCount <= 3'h3;
    valleyOnReq <= 1'b0;
    otp <= 1'b0;
    zcOvp <= 1'b0;
    swShort <= 1'b0;
    fbMv <= 2000;
    vccMv <= 12000;
    slope <= 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, `BMPC_REG_STATUS, '0);
    cmp(rd & 32'h0000_007F, 32'h0000_0020);
    cmp(startupCellEn, 1'b1);
    cmp(biasEnable, 1'b0);
    vccMv <= 18500;
    n0 = softCnt;
    waitReg(`BMPC_REG_STATUS, 32'h0000_0017, 32'h0000_0011);
    cmp(softCnt - n0, 1);
    apb(1'b1, `BMPC_REG_INT_MASK, 32'h0000_001F);
    apb(1'b0, `BMPC_REG_INT_MASK, '0);
    cmp(rd, 32'h0000_001F);
    apb(1'b0, 8'h10, '0);
    cmp(rd, 32'h0000_0000);
    cmp(apbErr, 1'b1);
    // Valley count short of seven must keep normal mode
    udCount <= 3'h6;
    fbMv <= 1000;
    repeat (1000) @(posedge mclk);
    apb(1'b0, `BMPC_REG_STATUS, '0);
    cmp(rd & 32'h0000_0007, 32'h0000_0001);
    udCount <= 3'h7;
    repeat (700) @(posedge mclk);
    apb(1'b0, `BMPC_REG_STATUS, '0);
    cmp(rd & 32'h0000_0007, 32'h0000_0001);
    waitReg(`BMPC_REG_STATUS, 32'h0000_0057, 32'h0000_0042);
    apb(1'b0, `BMPC_REG_INT_STAT, '0);
    cmp(rd & 32'h0000_0001, 32'h0000_0001);
    cmp(irq, 1'b1);
    fbMv <= 3700;
    waitReg(`BMPC_REG_STATUS, 32'h0000_0017, 32'h0000_0013);
    // Valley requests stay low, so every pulse comes from the burst timer
    for (int i = 0; i < 3; i++) begin
      slope <= (i == 0) ? 0 : 2 + int'($urandom % 6);
      gateWidth();
      gateWidth();
      c = (slope == 0) ? 400 : (340 + slope - 1) / slope;
      cmp(p, 800);
      cmpRange(w, c - 1, (slope == 0) ? 401 : c + 8);
    end
    fbMv <= 2900;
    waitReg(`BMPC_REG_STATUS, 32'h0000_0017, 32'h0000_0002);
    cmp(biasEnable, 1'b0);
    cmp(burstLimitSel, 1'b1);
    n0 = rises;
    repeat (1000) @(posedge mclk);
    cmp(rises - n0, 0);
    fbMv <= 4600;
    n0 = udCnt;
    waitReg(`BMPC_REG_STATUS, 32'h0000_0047, 32'h0000_0001);
    cmp(udCnt - n0, 1);
    apb(1'b0, `BMPC_REG_INT_STAT, '0);
    cmp(rd & 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, `BMPC_REG_INT_STAT, 32'h0000_001F);
    apb(1'b0, `BMPC_REG_INT_STAT, '0);
    cmp(rd, 32'h0000_0000);
    cmp(irq, 1'b0);
    apb(1'b1, `BMPC_REG_INT_MASK, 32'h0000_0000);
    fbMv <= 2000;
    udCount <= 3'h3;
    valleyOnReq <= 1'b1;
    slope <= 0;
    gateWidth();
    valleyOnReq <= 1'b0;
    cmpRange(w, 1199, 1201);
    apb(1'b0, `BMPC_REG_INT_STAT, '0);
    cmp(rd & 32'h0000_0010, 32'h0000_0010);
    cmp(irq, 1'b0);
    apb(1'b1, `BMPC_REG_INT_STAT, 32'h0000_0010);
    // A pull-up shorter than the blanking is a load step, not a fault
    fbMv <= 4950;
    repeat (30) @(posedge mclk);
    fbMv <= 2000;
    repeat (20) @(posedge mclk);
    apb(1'b0, `BMPC_REG_STATUS, '0);
    cmp(rd & 32'h0000_0007, 32'h0000_0001);
    for (int k = 0; k < 4; k++) begin
      n0 = softCnt;
      case (k)
        0: fbMv <= 4950;
        1: otp <= 1'b1;
        2: vccMv <= 26000;
        default: vccMv <= 9000;
      endcase
      waitReg(`BMPC_REG_INT_STAT, 32'h0000_0004, 32'h0000_0004);
      if (k < 3) begin
        apb(1'b0, `BMPC_REG_STATUS, '0);
        cmp(rd & 32'h0000_002F, 32'h0000_0004);
      end
      fbMv <= 2000;
      otp <= 1'b0;
      vccMv <= 10000;
      waitReg(`BMPC_REG_STATUS, 32'h0000_0027, 32'h0000_0020);
      vccMv <= 18500;
      waitReg(`BMPC_REG_STATUS, 32'h0000_0007, 32'h0000_0001);
      cmp(softCnt - n0, 1);
      apb(1'b1, `BMPC_REG_INT_STAT, 32'h0000_0004);
    end
    // Switching enable cleared must block every turn-on request
    apb(1'b1, `BMPC_REG_CTRL, 32'h0000_0000);
    valleyOnReq <= 1'b1;
    n0 = rises;
    repeat (100) @(posedge mclk);
    cmp(rises - n0, 0);
    apb(1'b0, `BMPC_REG_CTRL, '0);
    cmp(rd, 32'h0000_0000);
    valleyOnReq <= 1'b0;
    apb(1'b1, `BMPC_REG_CTRL, 32'h0000_0001);
    apb(1'b0, `BMPC_REG_CTRL, '0);
    cmp(rd, 32'h0000_0001);
    for (int j = 0; j < 2; j++) begin
      doReset();
      waitReg(`BMPC_REG_STATUS, 32'h0000_0007, 32'h0000_0001);
      zcOvp <= (j == 0);
      swShort <= (j == 1);
      valleyOnReq <= (j == 1);
      waitReg(`BMPC_REG_STATUS, 32'h0000_0007, 32'h0000_0005);
      zcOvp <= 1'b0;
      swShort <= 1'b0;
      valleyOnReq <= 1'b0;
      apb(1'b0, `BMPC_REG_INT_STAT, '0);
      cmp(rd & 32'h0000_0008, 32'h0000_0008);
      vccMv <= 10000;
      waitReg(`BMPC_REG_STATUS, 32'h0000_002F, 32'h0000_0025);
      vccMv <= 18500;
      waitReg(`BMPC_REG_STATUS, 32'h0000_002F, 32'h0000_0005);
    end
    stop_test();
  end
endmodule // burst_mode_protection_ctrl_test
`default_nettype wire
